// ===== common/sec_pkg.sv
package sec_pkg;

    // ************************************************************
    // geometry of the per-axis logs
    // ************************************************************
    localparam int AXES = 8;
    localparam int AXW = 3;
    localparam int SLOTW = 3;
    localparam int ADDRW = AXW + SLOTW;
    localparam int CODE_W = 16;
    localparam int CNT_W = 16;
    localparam logic [SLOTW-1:0] SLOT_FIRST = 3'h0;
    localparam logic [SLOTW-1:0] SLOT_LAST = 3'h6;
    localparam logic [SLOTW-1:0] LOG_DEPTH = 3'h7;
    localparam logic [SLOTW-1:0] IDX_FIRST = 3'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

    // ************************************************************
    // code ranges and word layout
    // ************************************************************
    localparam logic [CODE_W-1:0] AMP_MIN = 16'h0001;
    localparam logic [CODE_W-1:0] AMP_MAX = 16'h0fff;
    localparam logic [CODE_W-1:0] UNIT_MIN = 16'h1000;
    localparam int CODE_LSB = 0;
    localparam int MAIN_MSB = 7;
    localparam int SUB_LSB = 8;
    localparam int WHOLE_MSB = 11;

    // ************************************************************
    // listed amplifier codes
    // ************************************************************
    localparam logic [CODE_W-1:0] C_CTRL_UV = 16'h000b;
    localparam logic [CODE_W-1:0] C_OVERVOLT = 16'h000c;
    localparam logic [CODE_W-1:0] C_MAIN_UV = 16'h000d;
    localparam logic [CODE_W-1:0] C_MAIN_UV_AC = 16'h010d;
    localparam logic [CODE_W-1:0] C_OVERCUR = 16'h000e;
    localparam logic [CODE_W-1:0] C_PWR_MOD = 16'h010e;
    localparam logic [CODE_W-1:0] C_OVERHEAT = 16'h000f;
    localparam logic [CODE_W-1:0] C_OVERLOAD = 16'h0010;
    localparam logic [CODE_W-1:0] C_TRQ_SAT = 16'h0110;
    localparam logic [CODE_W-1:0] C_ENC_DISC = 16'h0015;
    localparam logic [CODE_W-1:0] C_ENC_COMM = 16'h0115;
    localparam logic [CODE_W-1:0] C_ENC_DATA = 16'h0017;
    localparam logic [CODE_W-1:0] C_POS_DEV = 16'h0018;
    localparam logic [CODE_W-1:0] C_SPD_DEV = 16'h0118;
    localparam logic [CODE_W-1:0] C_HYB_DEV = 16'h0019;
    localparam logic [CODE_W-1:0] C_CMD_ERR1 = 16'h041b;
    localparam logic [CODE_W-1:0] C_CMD_GEN = 16'h051b;
    localparam logic [CODE_W-1:0] C_CMD_CONT = 16'h061b;
    localparam logic [CODE_W-1:0] C_DEV_OVF1 = 16'h011d;
    localparam logic [CODE_W-1:0] C_DEV_OVF2 = 16'h021d;
    localparam logic [CODE_W-1:0] C_SAFE1 = 16'h001f;
    localparam logic [CODE_W-1:0] C_SAFE2 = 16'h021f;
    localparam logic [CODE_W-1:0] C_IF_DUP1 = 16'h0021;
    localparam logic [CODE_W-1:0] C_IF_DUP2 = 16'h0121;
    localparam logic [CODE_W-1:0] C_IF_FUNC1 = 16'h0221;
    localparam logic [CODE_W-1:0] C_IF_FUNC2 = 16'h0321;

    typedef enum logic [4:0] {
        CAT_NONE, CAT_CTRL_UV, CAT_OVERVOLT, CAT_MAIN_UV, CAT_MAIN_UV_AC,
        CAT_OVERCUR, CAT_PWR_MOD, CAT_OVERHEAT, CAT_OVERLOAD, CAT_TRQ_SAT,
        CAT_ENC_DISC, CAT_ENC_COMM, CAT_ENC_DATA, CAT_POS_DEV, CAT_SPD_DEV,
        CAT_HYB_DEV, CAT_CMD_ERR1, CAT_CMD_GEN, CAT_CMD_CONT, CAT_DEV_OVF,
        CAT_SAFETY, CAT_IF_DUP, CAT_IF_FUNC, CAT_UNIT, CAT_UNLISTED
    } sec_cat_e;

    // reported event: axis plus the raw double word
    typedef struct packed {
        logic [AXW-1:0] axis;
        logic [31:0] word;
    } sec_evt_s;

    // decoded event, digits in bcd
    typedef struct packed {
        logic is_amp;
        logic is_unit;
        logic unlisted;
        sec_cat_e cat;
        logic [AXW-1:0] axis;
        logic [CODE_W-1:0] code;
        logic [11:0] main_bcd;
        logic [11:0] sub_bcd;
        logic [15:0] whole_bcd;
    } sec_dec_s;

    // shift-add-3 conversion of up to twelve bits
    function automatic logic [15:0] sec_bin2bcd(input logic [11:0] bin);
        logic [27:0] sh;
        sh = {16'h0000, bin};
        for (int i = 0; i < 12; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (sh[12 + 4*d +: 4] > 4'h4) begin
                    sh[12 + 4*d +: 4] = sh[12 + 4*d +: 4] + 4'h3;
                end
            end
            sh = {sh[26:0], 1'b0};
        end
        return sh[27:12];
    endfunction

endpackage

// ===== rtl/sec_log_mem.sv
`timescale 1ns/100ps
module sec_log_mem
    import sec_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic we, // write strobe
    input wire logic [ADDRW-1:0] waddr, // axis and slot
    input wire logic [CODE_W-1:0] wdata, // code to store
    input wire logic [ADDRW-1:0] raddr, // axis and slot
    output logic [CODE_W-1:0] rdata // registered read data
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [CODE_W-1:0] mem [2**ADDRW];
    logic [CODE_W-1:0] rdata_r, rdata_nxt;

    // array has no reset; stale slots are masked by the owner
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read always, one cycle latency
    always_comb begin
        rdata_nxt = mem[raddr];
    end

    // output register keeps read data off the array
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

endmodule

// ===== rtl/sec_decoder.sv
`timescale 1ns/100ps
// Contract
// R1: codes 0001h..0fffh are amplifier alarms
// R2: codes 1000h and up are unit errors
// R3: new series: low byte main, high sub
// R4: main and sub shown as decimal
// R5: old series: whole code as decimal
// R6: amplifier alarm frees the servomotor
// R7: host clears, then re-requests servo on
// R8: supply voltage alarm codes mapped
// R9: overload, current, heat codes mapped
// R10: encoder communication codes mapped
// R11: deviation excess codes mapped
// R12: command alarm codes mapped
// R13: counter overflow, safety codes mapped
// R14: interface input allocation codes mapped
// R15: low word of double word holds code
// R16: seven-entry log, count, newest first
// R17: clear wipes that axis log
// R18: errored axis refuses operation until clear
// R19: unlisted amplifier codes pass, flagged
module sec_decoder
    import sec_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic evt_valid, // error report pulse
    input wire sec_evt_s evt, // axis and raw word
    input wire logic [AXES-1:0] amp_new_series, // per axis amplifier style
    input wire logic clr_valid, // error clear pulse
    input wire logic [AXW-1:0] clr_axis, // axis to clear
    input wire logic [AXES-1:0] son_req, // servo on request pulses
    input wire logic [AXES-1:0] soff_req, // servo off request pulses
    input wire logic rd_req, // log read pulse
    input wire logic [AXW-1:0] rd_axis, // log axis to read
    input wire logic [SLOTW-1:0] rd_idx, // buffer 1..7, 1 newest
    output sec_dec_s dec, // last decoded event
    output logic dec_valid, // pulse with new dec
    output logic [CODE_W-1:0] rd_code, // buffer contents
    output logic [CNT_W-1:0] rd_count, // occurrences on axis
    output logic rd_valid, // pulse with read data
    output logic [AXES-1:0] servo_on, // axis energised
    output logic [AXES-1:0] axis_locked, // error pending
    output logic [AXES-1:0] op_enable // axis may operate
);

    // ************************************************************
    // combinational classification
    // ************************************************************
    logic [CODE_W-1:0] code;
    sec_dec_s dec_c;
    sec_cat_e cat_c;

    // upper word of the double word is ignored
    // R15: low word code
    assign code = evt.word[CODE_LSB +: CODE_W];

    // map of listed codes
    always_comb begin
        cat_c = CAT_NONE;
        unique case (code)
            // R8: supply alarms
            C_CTRL_UV: cat_c = CAT_CTRL_UV;
            C_OVERVOLT: cat_c = CAT_OVERVOLT;
            C_MAIN_UV: cat_c = CAT_MAIN_UV;
            C_MAIN_UV_AC: cat_c = CAT_MAIN_UV_AC;
            // R9: load and heat
            C_OVERCUR: cat_c = CAT_OVERCUR;
            C_PWR_MOD: cat_c = CAT_PWR_MOD;
            C_OVERHEAT: cat_c = CAT_OVERHEAT;
            C_OVERLOAD: cat_c = CAT_OVERLOAD;
            C_TRQ_SAT: cat_c = CAT_TRQ_SAT;
            // R10: encoder link
            C_ENC_DISC: cat_c = CAT_ENC_DISC;
            C_ENC_COMM: cat_c = CAT_ENC_COMM;
            C_ENC_DATA: cat_c = CAT_ENC_DATA;
            // R11: deviation excess
            C_POS_DEV: cat_c = CAT_POS_DEV;
            C_SPD_DEV: cat_c = CAT_SPD_DEV;
            C_HYB_DEV: cat_c = CAT_HYB_DEV;
            // R12: command alarms
            C_CMD_ERR1: cat_c = CAT_CMD_ERR1;
            C_CMD_GEN: cat_c = CAT_CMD_GEN;
            C_CMD_CONT: cat_c = CAT_CMD_CONT;
            // R13: overflow and safety
            C_DEV_OVF1, C_DEV_OVF2: cat_c = CAT_DEV_OVF;
            C_SAFE1, C_SAFE2: cat_c = CAT_SAFETY;
            // R14: interface inputs
            C_IF_DUP1, C_IF_DUP2: cat_c = CAT_IF_DUP;
            C_IF_FUNC1, C_IF_FUNC2: cat_c = CAT_IF_FUNC;
            default: cat_c = CAT_NONE;
        endcase
    end

    // range split and decimal digits
    always_comb begin
        dec_c = '0;
        dec_c.code = code;
        dec_c.axis = evt.axis;
        // R1: amplifier range
        dec_c.is_amp = (code >= AMP_MIN) && (code <= AMP_MAX);
        // R2: unit range
        dec_c.is_unit = (code >= UNIT_MIN);
        dec_c.cat = cat_c;
        if (dec_c.is_unit) begin
            dec_c.cat = CAT_UNIT;
        end
        // R19: unlisted passes flagged
        if (dec_c.is_amp && (cat_c == CAT_NONE)) begin
            dec_c.cat = CAT_UNLISTED;
            dec_c.unlisted = 1'b1;
        end
        if (dec_c.is_amp && amp_new_series[evt.axis]) begin
            // R3: low main, high sub
            // R4: decimal main and sub
            dec_c.main_bcd = 12'(sec_bin2bcd({4'h0, code[MAIN_MSB:CODE_LSB]}));
            dec_c.sub_bcd = 12'(sec_bin2bcd({4'h0, code[CODE_W-1:SUB_LSB]}));
        end else if (dec_c.is_amp) begin
            // R5: whole code decimal
            dec_c.whole_bcd = sec_bin2bcd(code[WHOLE_MSB:CODE_LSB]);
        end
    end

    // ************************************************************
    // per-axis state
    // ************************************************************
    logic [CNT_W-1:0] cnt_r [AXES];
    logic [CNT_W-1:0] cnt_nxt [AXES];
    logic [SLOTW-1:0] head_r [AXES];
    logic [SLOTW-1:0] head_nxt [AXES];
    logic [AXES-1:0] lock_r, lock_nxt, son_r, son_nxt;
    sec_dec_s dec_r, dec_nxt;
    logic dec_valid_r, dec_valid_nxt;
    logic we;
    logic [ADDRW-1:0] waddr;

    // a clear and an event in one cycle: the event lands in a fresh log
    always_comb begin
        dec_nxt = dec_r;
        dec_valid_nxt = evt_valid;
        lock_nxt = lock_r;
        son_nxt = son_r;
        we = 1'b0;
        waddr = {evt.axis, SLOT_FIRST};
        if (evt_valid) begin
            dec_nxt = dec_c;
        end
        for (int a = 0; a < AXES; a++) begin
            cnt_nxt[a] = cnt_r[a];
            head_nxt[a] = head_r[a];
            // R17: clear wipes log
            if (clr_valid && (clr_axis == AXW'(a))) begin
                cnt_nxt[a] = CNT_ZERO;
                head_nxt[a] = SLOT_FIRST;
                lock_nxt[a] = 1'b0;
            end
            // R18: servo on only when cleared
            if (son_req[a] && !lock_nxt[a]) begin
                son_nxt[a] = 1'b1;
            end
            if (soff_req[a]) begin
                son_nxt[a] = 1'b0;
            end
            if (evt_valid && (evt.axis == AXW'(a)) && (dec_c.is_amp || dec_c.is_unit)) begin
                // R18: lock until clear, set wins
                lock_nxt[a] = 1'b1;
                // R6: amplifier alarm frees motor
                if (dec_c.is_amp) begin
                    son_nxt[a] = 1'b0;
                end
                // R16: ring write, newest at head
                if (cnt_nxt[a] == CNT_ZERO) begin
                    head_nxt[a] = SLOT_FIRST;
                end else if (head_r[a] == SLOT_LAST) begin
                    head_nxt[a] = SLOT_FIRST;
                end else begin
                    head_nxt[a] = head_r[a] + IDX_FIRST;
                end
                if (cnt_nxt[a] != CNT_MAX) begin
                    cnt_nxt[a] = cnt_nxt[a] + CNT_ONE;
                end
                we = 1'b1;
                waddr = {evt.axis, head_nxt[a]};
            end
        end
    end

    // register per-axis state and decode result
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int a = 0; a < AXES; a++) begin
                cnt_r[a] <= CNT_ZERO;
                head_r[a] <= SLOT_FIRST;
            end
            lock_r <= '0;
            son_r <= '0;
            dec_r <= '0;
            dec_valid_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            head_r <= head_nxt;
            lock_r <= lock_nxt;
            son_r <= son_nxt;
            dec_r <= dec_nxt;
            dec_valid_r <= dec_valid_nxt;
        end
    end

    // ************************************************************
    // log read path
    // ************************************************************
    logic [SLOTW-1:0] rd_d, rd_slot;
    logic rd_ok;
    logic [SLOTW-1:0] rd_head;
    logic [CNT_W-1:0] rd_cnt_c;
    logic [CODE_W-1:0] mem_rdata;
    logic rd_p1_r, rd_p1_nxt, rd_ok_r, rd_ok_nxt;
    logic [CNT_W-1:0] rd_cnt_r, rd_cnt_nxt, rd_count_r, rd_count_nxt;
    logic [CODE_W-1:0] rd_code_r, rd_code_nxt;
    logic rd_valid_r, rd_valid_nxt;

    // R16: buffer 1 newest, masked past count
    always_comb begin
        rd_head = head_r[rd_axis];
        rd_cnt_c = cnt_r[rd_axis];
        rd_d = rd_idx - IDX_FIRST;
        rd_slot = (rd_head >= rd_d) ? (rd_head - rd_d) : (rd_head + LOG_DEPTH - rd_d);
        rd_ok = (rd_idx >= IDX_FIRST) && (rd_idx <= LOG_DEPTH)
                && (CNT_W'(rd_idx) <= rd_cnt_c);
    end

    // two stages: memory then mask, so outputs come from flops
    always_comb begin
        rd_p1_nxt = rd_req;
        rd_ok_nxt = rd_ok;
        rd_cnt_nxt = rd_cnt_c;
        rd_valid_nxt = rd_p1_r;
        rd_code_nxt = rd_code_r;
        rd_count_nxt = rd_count_r;
        if (rd_p1_r) begin
            rd_code_nxt = rd_ok_r ? mem_rdata : '0;
            rd_count_nxt = rd_cnt_r;
        end
    end

    // register the read pipeline
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_p1_r <= 1'b0;
            rd_ok_r <= 1'b0;
            rd_cnt_r <= CNT_ZERO;
            rd_valid_r <= 1'b0;
            rd_code_r <= '0;
            rd_count_r <= CNT_ZERO;
        end else begin
            rd_p1_r <= rd_p1_nxt;
            rd_ok_r <= rd_ok_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_code_r <= rd_code_nxt;
            rd_count_r <= rd_count_nxt;
        end
    end

    sec_log_mem u_mem (
        .clk(clk),
        .nrst(nrst),
        .we(we),
        .waddr(waddr),
        .wdata(code),
        .raddr({rd_axis, rd_slot}),
        .rdata(mem_rdata)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    assign dec = dec_r;
    assign dec_valid = dec_valid_r;
    assign rd_code = rd_code_r;
    assign rd_count = rd_count_r;
    assign rd_valid = rd_valid_r;
    assign servo_on = son_r;
    assign axis_locked = lock_r;
    // R18: no operation while locked
    assign op_enable = son_r & ~lock_r;

endmodule

// ===== dv/sec_amp_model.sv
`timescale 1ns/100ps
module sec_amp_model
    import sec_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic raise, // alarm request from bench
    input wire logic [AXW-1:0] raise_axis, // axis in alarm
    input wire logic [CODE_W-1:0] raise_code, // alarm code
    input wire logic [15:0] raise_hi, // upper word, normally zero
    output logic evt_valid, // one-cycle report
    output sec_evt_s evt // axis and double word
);
    // ************************************************************
    // alarm reporting
    // ************************************************************
    // code in low word
    // idle word flips every cycle so a stale copy is never mistaken for data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            evt_valid <= 1'b0;
            evt <= '0;
        end else if (raise) begin
            evt_valid <= 1'b1;
            evt <= {raise_axis, raise_hi, raise_code};
        end else begin
            evt_valid <= 1'b0;
            evt <= ~evt;
        end
    end
endmodule

// ===== dv/sec_decoder_chk.sv
`timescale 1ns/100ps
module sec_decoder_chk
    import sec_pkg::*;
(
    input wire logic clk, // clock
    input wire logic nrst, // reset
    input wire logic evt_valid, // report
    input wire sec_evt_s evt, // report data
    input wire logic [AXES-1:0] amp_new_series, // series
    input wire logic clr_valid, // clear
    input wire logic [AXW-1:0] clr_axis, // clear axis
    input wire logic [AXES-1:0] son_req, // servo on
    input wire logic [AXES-1:0] soff_req, // servo off
    input wire logic rd_req, // read
    input wire logic [AXW-1:0] rd_axis, // read axis
    input wire logic [SLOTW-1:0] rd_idx, // read slot
    input wire sec_dec_s dec, // decoded
    input wire logic dec_valid, // decoded pulse
    input wire logic [CODE_W-1:0] rd_code, // read code
    input wire logic [CNT_W-1:0] rd_count, // read count
    input wire logic rd_valid, // read pulse
    input wire logic [AXES-1:0] servo_on, // energised
    input wire logic [AXES-1:0] axis_locked, // locked
    input wire logic [AXES-1:0] op_enable // may operate
);
    logic amp_in;
    // amplifier range report this cycle
    assign amp_in = evt_valid && evt.word[15:0] >= AMP_MIN && evt.word[15:0] <= AMP_MAX;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ************************************************************
    // decode and axis state
    // ************************************************************
    dec_pulse_a: assert property (
        1'b1 |=> dec_valid == $past(evt_valid)) else $error("dec_valid not one cycle after report");
    amp_class_a: assert property (
        amp_in |=> dec.is_amp && !dec.is_unit) else $error("amplifier code misclassified");
    unit_class_a: assert property (
        evt_valid && evt.word[15:0] >= UNIT_MIN |=> dec.is_unit && !dec.is_amp
        && dec.cat == CAT_UNIT) else $error("unit code misclassified");
    code_low_a: assert property (
        evt_valid |=> dec.code == $past(evt.word[15:0])) else $error("code not low word");
    main_sub_a: assert property (
        evt_valid && evt.word[15:0] == C_ENC_COMM && amp_new_series[evt.axis]
        |=> dec.main_bcd == 12'h021 && dec.sub_bcd == 12'h001) else $error("main sub wrong");
    free_servo_a: assert property (
        amp_in |=> !servo_on[$past(evt.axis)]) else $error("servo not freed");
    lock_set_a: assert property (
        amp_in |=> axis_locked[$past(evt.axis)]) else $error("axis not locked");
    lock_hold_a: assert property (
        !clr_valid |=> (axis_locked & $past(axis_locked)) == $past(axis_locked))
        else $error("lock dropped without clear");
    clear_lock_a: assert property (
        clr_valid && !(evt_valid && evt.axis == clr_axis) |=> !axis_locked[$past(clr_axis)])
        else $error("clear left lock");
    read_lat_a: assert property (
        rd_req |-> ##2 rd_valid) else $error("read answer late");
    unlisted_flag_a: assert property (
        dec_valid && dec.unlisted |-> dec.is_amp && dec.cat == CAT_UNLISTED)
        else $error("unlisted flag wrong");
    cover property (dec_valid && dec.is_unit);
    cover property (dec_valid && dec.unlisted);
    cover property (servo_on != '0);
    cover property (rd_valid && rd_count > CNT_ONE);
endmodule

bind sec_decoder sec_decoder_chk i_sec_decoder_chk (
    .clk(clk), .nrst(nrst), .evt_valid(evt_valid), .evt(evt),
    .amp_new_series(amp_new_series), .clr_valid(clr_valid), .clr_axis(clr_axis),
    .son_req(son_req), .soff_req(soff_req), .rd_req(rd_req), .rd_axis(rd_axis),
    .rd_idx(rd_idx), .dec(dec), .dec_valid(dec_valid), .rd_code(rd_code),
    .rd_count(rd_count), .rd_valid(rd_valid), .servo_on(servo_on),
    .axis_locked(axis_locked), .op_enable(op_enable)
);

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench
    import sec_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic raise = 1'b0;
    logic [AXW-1:0] raise_axis = '0;
    logic [CODE_W-1:0] raise_code = '0;
    logic [15:0] raise_hi = 16'h0000;
    logic [AXES-1:0] amp_new_series = 8'hfd;
    logic clr_valid = 1'b0;
    logic [AXW-1:0] clr_axis = '0;
    logic [AXES-1:0] son_req = '0;
    logic [AXES-1:0] soff_req = '0;
    logic rd_req = 1'b0;
    logic [AXW-1:0] rd_axis = '0;
    logic [SLOTW-1:0] rd_idx = '0;
    logic evt_valid, dec_valid, rd_valid;
    sec_evt_s evt;
    sec_dec_s dec;
    logic [CODE_W-1:0] rd_code;
    logic [CNT_W-1:0] rd_count;
    logic [AXES-1:0] servo_on, axis_locked, op_enable;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    logic [15:0] codes [26] = '{16'h000b, 16'h000c, 16'h000d, 16'h010d, 16'h000e, 16'h010e,
        16'h000f, 16'h0010, 16'h0110, 16'h0015, 16'h0115, 16'h0017, 16'h0018, 16'h0118,
        16'h0019, 16'h041b, 16'h051b, 16'h061b, 16'h011d, 16'h021d, 16'h001f, 16'h021f,
        16'h0021, 16'h0121, 16'h0221, 16'h0321};

    sec_amp_model i_sec_amp_model (.clk(clk), .nrst(nrst), .raise(raise),
        .raise_axis(raise_axis), .raise_code(raise_code), .raise_hi(raise_hi),
        .evt_valid(evt_valid), .evt(evt));
    sec_decoder i_sec_decoder (.clk(clk), .nrst(nrst), .evt_valid(evt_valid), .evt(evt),
        .amp_new_series(amp_new_series), .clr_valid(clr_valid), .clr_axis(clr_axis),
        .son_req(son_req), .soff_req(soff_req), .rd_req(rd_req), .rd_axis(rd_axis),
        .rd_idx(rd_idx), .dec(dec), .dec_valid(dec_valid), .rd_code(rd_code),
        .rd_count(rd_count), .rd_valid(rd_valid), .servo_on(servo_on),
        .axis_locked(axis_locked), .op_enable(op_enable));

    // ************************************************************
    // clock, timeout and shared tasks
    // ************************************************************
    always #25 clk = ~clk;

    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] to_bcd(input int n);
        return {4'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
    endfunction

    // alarm through the amplifier model, returns with dec settled
    task automatic report(input logic [2:0] ax, input logic [15:0] code);
        raise <= 1'b1;
        raise_axis <= ax;
        raise_code <= code;
        @(posedge clk);
        raise <= 1'b0;
        for (int i = 0; i < 8 && dec_valid !== 1'b1; i++) @(posedge clk);
        check("dec_valid", dec_valid, 32'h1);
    endtask

    task automatic clear(input logic [2:0] ax);
        clr_valid <= 1'b1;
        clr_axis <= ax;
        @(posedge clk);
        clr_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic servo(input logic on, input logic [2:0] ax);
        if (on) son_req <= 8'h01 << ax;
        else soff_req <= 8'h01 << ax;
        @(posedge clk);
        son_req <= '0;
        soff_req <= '0;
        repeat (2) @(posedge clk);
    endtask

    task automatic read_log(input logic [2:0] ax, input logic [2:0] idx);
        rd_req <= 1'b1;
        rd_axis <= ax;
        rd_idx <= idx;
        @(posedge clk);
        rd_req <= 1'b0;
        for (int i = 0; i < 8 && rd_valid !== 1'b1; i++) @(posedge clk);
        check("rd_valid", rd_valid, 32'h1);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    // every listed code mapped and split
    task automatic t_table();
        for (int i = 0; i < 26; i++) begin
            report(0, codes[i]);
            check("cat", dec.cat, i < 18 ? i + 1 : 19 + (i - 18) / 2);
            check("main", dec.main_bcd, to_bcd(codes[i][7:0]) & 16'h0fff);
            check("sub", dec.sub_bcd, to_bcd(codes[i][15:8]) & 16'h0fff);
            check("unlisted", dec.unlisted, 32'h0);
        end
    endtask

    // old series whole code, range edges
    task automatic t_series();
        report(1, 16'h0010);
        check("whole", dec.whole_bcd, 32'h0016);
        check("main0", dec.main_bcd, 32'h0);
        report(1, 16'h0fff);
        check("whole", dec.whole_bcd, 32'h4095);
        check("amp", dec.is_amp, 32'h1);
        report(1, 16'h0001);
        check("amp", dec.is_amp, 32'h1);
    endtask

    // unit codes, zero code, upper word ignored
    task automatic t_unit();
        report(2, 16'h1000);
        check("unit", {dec.is_unit, dec.is_amp}, 32'h2);
        check("cat", dec.cat, CAT_UNIT);
        report(2, 16'hffff);
        check("unit", {dec.is_unit, dec.is_amp}, 32'h2);
        report(2, 16'h0000);
        check("zero", {dec.is_unit, dec.is_amp}, 32'h0);
        raise_hi <= 16'habcd;
        report(2, C_ENC_DISC);
        raise_hi <= 16'h0000;
        check("code", dec.code, 32'h0015);
        check("axis", dec.axis, 32'h2);
        check("cat", dec.cat, CAT_ENC_DISC);
        report(0, 16'h0012);
        check("unlisted", {dec.unlisted, dec.is_amp}, 32'h3);
        check("code", dec.code, 32'h0012);
    endtask

    // alarm frees servo, relock until clear
    task automatic t_servo();
        clear(3);
        servo(1, 3);
        check("servo", servo_on[3], 32'h1);
        check("op", op_enable[3], 32'h1);
        report(3, C_OVERLOAD);
        check("servo", servo_on[3], 32'h0);
        check("lock", axis_locked[3], 32'h1);
        check("op", op_enable[3], 32'h0);
        servo(1, 3);
        check("servo", servo_on[3], 32'h0);
        clear(3);
        servo(1, 3);
        check("servo", servo_on[3], 32'h1);
        servo(0, 3);
        check("servo", servo_on[3], 32'h0);
    endtask

    task automatic t_log();
        clear(4);
        for (int i = 0; i < 8; i++) report(4, codes[i]);
        read_log(4, 1);
        check("newest", rd_code, codes[7]);
        check("count", rd_count, 32'h8);
        read_log(4, 7);
        check("oldest", rd_code, codes[1]);
        read_log(4, 0);
        check("idx0", rd_code, 32'h0);
        clear(4);
        check("lock", axis_locked[4], 32'h0);
        read_log(4, 1);
        check("wiped", rd_code, 32'h0);
        check("count", rd_count, 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check("idle", {servo_on, axis_locked, dec_valid, rd_valid}, 32'h0);
        t_table();
        t_series();
        t_unit();
        t_servo();
        t_log();
        test_done();
    end
endmodule
